// *** logic/fixed_ref_pkg.sv ***
// Constants and types shared by the fixed reference control logic
package fixed_ref_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned WB_ADDR_W = 8;
  localparam int unsigned WB_DATA_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned REG_W = 8;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [WB_ADDR_W-1:0] FIXED_REF_CONTROL_ADDR = 8'h00;
  localparam logic [REG_W-1:0] FIXED_REF_CONTROL_RESET = 8'h00;

  // ************************************************************
  // Field positions in fixed_ref_control
  // ************************************************************
  localparam int unsigned REF_ENABLE_BIT = 7;
  localparam int unsigned REF_READY_BIT = 6;
  localparam int unsigned TEMP_SENSE_ENABLE_BIT = 5;
  localparam int unsigned TEMP_RANGE_SELECT_BIT = 4;
  localparam int unsigned CMP_DAC_GAIN_LSB = 2;
  localparam int unsigned ADC_GAIN_LSB = 0;
  localparam int unsigned GAIN_W = 2;
  // Bits software can store; ready is status only
  localparam logic [REG_W-1:0] CTRL_WRITE_MASK = 8'hBF;

  // ************************************************************
  // Buffer gain encodings
  // ************************************************************
  typedef enum logic [GAIN_W-1:0] {
    GAIN_OFF = 2'h0,
    GAIN_X1 = 2'h1,
    GAIN_X2 = 2'h2,
    GAIN_X4 = 2'h3
  } gain_code_t;
  localparam int unsigned MULT_W = 3;
  localparam logic [MULT_W-1:0] MULT_NONE = 3'h0;
  localparam logic [MULT_W-1:0] MULT_X1 = 3'h1;
  localparam logic [MULT_W-1:0] MULT_X2 = 3'h2;
  localparam logic [MULT_W-1:0] MULT_X4 = 3'h4;

  // ************************************************************
  // Converter channel of the temperature output
  // ************************************************************
  localparam int unsigned CHAN_W = 5;
  localparam logic [CHAN_W-1:0] TEMP_ADC_CHANNEL = 5'h1D;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned REF_SETTLE_NS = 1000;
  localparam int unsigned REF_SETTLE_CYCLES =
    (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CNT_W = 8;

endpackage : fixed_ref_pkg

// *** logic/ref_gain_decode.sv ***
// Decodes a buffer gain code into registered on and multiplier outputs
`timescale 1ns/1ps
module ref_gain_decode
  import fixed_ref_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ref_on_i,
  input wire logic [fixed_ref_pkg::GAIN_W-1:0] gain_code_i,
  output logic buf_on_o,
  output logic [fixed_ref_pkg::MULT_W-1:0] buf_mult_o
);

  function automatic logic [MULT_W-1:0] code_to_mult(
    input logic [GAIN_W-1:0] code
  );
    logic [MULT_W-1:0] m;
    m = MULT_NONE;
    case (gain_code_t'(code))
      GAIN_OFF: m = MULT_NONE;
      GAIN_X1: m = MULT_X1;
      GAIN_X2: m = MULT_X2;
      GAIN_X4: m = MULT_X4;
      default: m = MULT_NONE;
    endcase
    return m;
  endfunction : code_to_mult

  // A disabled reference leaves every buffer unpowered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      buf_on_o <= 1'b0;
      buf_mult_o <= MULT_NONE;
    end else if (ref_on_i && gain_code_i != GAIN_OFF) begin
      buf_on_o <= 1'b1;
      buf_mult_o <= code_to_mult(gain_code_i);
    end else begin
      buf_on_o <= 1'b0;
      buf_mult_o <= MULT_NONE;
    end
  end

endmodule : ref_gain_decode

// *** logic/temp_sense_ctrl.sv ***
// Bias, range and converter hookup of the die temperature circuit
`timescale 1ns/1ps
module temp_sense_ctrl
  import fixed_ref_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic range_high_i,
  input wire logic [fixed_ref_pkg::CHAN_W-1:0] adc_chan_sel_i,
  output logic bias_on_o,
  output logic high_range_o,
  output logic adc_connect_o
);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bias_on_o <= 1'b0;
    end else begin
      bias_on_o <= enable_i;
    end
  end

  // Range is held low while disabled so the bias draws nothing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      high_range_o <= 1'b0;
    end else begin
      high_range_o <= enable_i & range_high_i;
    end
  end

  // Only this source may drive the reserved converter channel
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      adc_connect_o <= 1'b0;
    end else begin
      adc_connect_o <= enable_i && adc_chan_sel_i == TEMP_ADC_CHANNEL;
    end
  end

endmodule : temp_sense_ctrl

// *** logic/fixed_ref_temp_sense_ctrl.sv ***
// Fixed reference and temperature sensor control register with bus slave
`timescale 1ns/1ps
module fixed_ref_temp_sense_ctrl
  import fixed_ref_pkg::*;
#(
  parameter bit HAS_LDO = 1'b1,
  parameter int unsigned SETTLE_CYCLES = fixed_ref_pkg::REF_SETTLE_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fixed_ref_pkg::WB_ADDR_W-1:0] wb_adr_i,
  input wire logic [fixed_ref_pkg::WB_DATA_W-1:0] wb_dat_i,
  input wire logic [fixed_ref_pkg::WB_SEL_W-1:0] wb_sel_i,
  output logic [fixed_ref_pkg::WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [fixed_ref_pkg::CHAN_W-1:0] adc_chan_sel_i,
  output logic ref_enable_o,
  output logic ref_ready_o,
  output logic adc_buf_on_o,
  output logic [fixed_ref_pkg::MULT_W-1:0] adc_buf_mult_o,
  output logic cmp_dac_buf_on_o,
  output logic [fixed_ref_pkg::MULT_W-1:0] cmp_dac_buf_mult_o,
  output logic temp_bias_on_o,
  output logic temp_high_range_o,
  output logic temp_adc_connect_o
);

  import fixed_ref_pkg::*;

  // ************************************************************
  // Control register
  // ************************************************************
  logic [REG_W-1:0] ctrl_q;
  logic ready_q;
  logic [SETTLE_CNT_W-1:0] settle_q;
  logic req;
  logic hit;
  logic wr_en;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign hit = wb_adr_i == FIXED_REF_CONTROL_ADDR;
  // Only lane 0 carries this narrow register
  assign wr_en = req & wb_we_i & hit & wb_sel_i[0];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= FIXED_REF_CONTROL_RESET;
    end else if (wr_en) begin
      ctrl_q <= wb_dat_i[REG_W-1:0] & CTRL_WRITE_MASK;
    end
  end

  // ************************************************************
  // Reference readiness
  // ************************************************************
  // Without the regulator the reference needs time to settle after
  // enable; a disable drops ready at once and restarts the wait.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      settle_q <= '0;
    end else if (!ctrl_q[REF_ENABLE_BIT]) begin
      settle_q <= '0;
    end else if (settle_q != SETTLE_CNT_W'(SETTLE_CYCLES)) begin
      settle_q <= settle_q + SETTLE_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_q <= HAS_LDO;
    end else if (HAS_LDO) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ctrl_q[REF_ENABLE_BIT] &&
                 settle_q == SETTLE_CNT_W'(SETTLE_CYCLES);
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************
  // Every access is acked one cycle later; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i && hit) begin
      wb_dat_o <= {{(WB_DATA_W-REG_W){1'b0}},
                   ctrl_q[REG_W-1:REF_READY_BIT+1], ready_q,
                   ctrl_q[REF_READY_BIT-1:0]};
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ref_enable_o <= 1'b0;
      ref_ready_o <= 1'b0;
    end else begin
      ref_enable_o <= ctrl_q[REF_ENABLE_BIT];
      ref_ready_o <= ready_q;
    end
  end

  ref_gain_decode u_adc_gain (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ref_on_i(ctrl_q[REF_ENABLE_BIT]),
    .gain_code_i(ctrl_q[ADC_GAIN_LSB +: GAIN_W]),
    .buf_on_o(adc_buf_on_o),
    .buf_mult_o(adc_buf_mult_o)
  );

  ref_gain_decode u_cmp_dac_gain (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ref_on_i(ctrl_q[REF_ENABLE_BIT]),
    .gain_code_i(ctrl_q[CMP_DAC_GAIN_LSB +: GAIN_W]),
    .buf_on_o(cmp_dac_buf_on_o),
    .buf_mult_o(cmp_dac_buf_mult_o)
  );

  temp_sense_ctrl u_temp (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl_q[TEMP_SENSE_ENABLE_BIT]),
    .range_high_i(ctrl_q[TEMP_RANGE_SELECT_BIT]),
    .adc_chan_sel_i(adc_chan_sel_i),
    .bias_on_o(temp_bias_on_o),
    .high_range_o(temp_high_range_o),
    .adc_connect_o(temp_adc_connect_o)
  );

endmodule : fixed_ref_temp_sense_ctrl

// *** test/fixed_ref_monitor.sv ***
// Port assertions for the fixed reference control block
`timescale 1ns/1ps
module fixed_ref_monitor
  import fixed_ref_pkg::*;
#(parameter bit HAS_LDO = 1'b1)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [4:0] adc_chan_sel_i,
  input wire logic ref_enable_o,
  input wire logic ref_ready_o,
  input wire logic adc_buf_on_o,
  input wire logic [2:0] adc_buf_mult_o,
  input wire logic cmp_dac_buf_on_o,
  input wire logic [2:0] cmp_dac_buf_mult_o,
  input wire logic temp_bias_on_o,
  input wire logic temp_high_range_o,
  input wire logic temp_adc_connect_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ************************************************************
  // Bus requests
  // ************************************************************
  sequence req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wr_taken;
    req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00);
  endsequence
  sequence rd_taken;
    req ##0 (!wb_we_i && wb_adr_i == 8'h00);
  endsequence
  chk_ack_answer: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  chk_write_lands: assert property (wr_taken |-> ##2
    ref_enable_o == $past(wb_dat_i[7], 2) &&
    temp_bias_on_o == $past(wb_dat_i[5], 2))
    else $error("written control bits not applied");
  chk_read_view: assert property (rd_taken |=>
    wb_dat_o[31:8] == 24'h0 &&
    wb_dat_o[7:5] == {ref_enable_o, ref_ready_o, temp_bias_on_o})
    else $error("read data disagrees with outputs");
  chk_ready_ldo: assert property (
    HAS_LDO && !$past(rst_i) |-> ref_ready_o)
    else $error("ready low with regulator fitted");
  chk_adc_code: assert property ($onehot0(adc_buf_mult_o) &&
    adc_buf_on_o == (adc_buf_mult_o != 3'h0))
    else $error("adc buffer multiplier malformed");
  chk_cmp_code: assert property ($onehot0(cmp_dac_buf_mult_o) &&
    cmp_dac_buf_on_o == (cmp_dac_buf_mult_o != 3'h0))
    else $error("cmp buffer multiplier malformed");
  chk_buf_needs_ref: assert property (adc_buf_on_o || cmp_dac_buf_on_o
    |-> ref_enable_o) else $error("buffer on with reference off");
  chk_range_bias: assert property (
    temp_high_range_o |-> temp_bias_on_o)
    else $error("high range without sensor bias");
  chk_chan_link: assert property (temp_adc_connect_o ==
    (temp_bias_on_o && $past(adc_chan_sel_i) == 5'h1D))
    else $error("sensor channel hookup wrong");
endmodule : fixed_ref_monitor

bind fixed_ref_temp_sense_ctrl fixed_ref_monitor #(.HAS_LDO(HAS_LDO))
  i_mon (.*);

// *** test/fixed_ref_temp_sense_ctrl_tb.sv ***
// Self-checking bench for the fixed reference control register
`timescale 1ns/1ps
module fixed_ref_temp_sense_ctrl_tb;
  import fixed_ref_pkg::*;
  logic ref_clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h0;
  logic [4:0] adc_chan_sel_i = 5'h00;
  logic ref_enable_o, ref_ready_o, adc_buf_on_o, cmp_dac_buf_on_o;
  logic temp_bias_on_o, temp_high_range_o, temp_adc_connect_o;
  logic [2:0] adc_buf_mult_o, cmp_dac_buf_mult_o;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  fixed_ref_temp_sense_ctrl #(.HAS_LDO(1'b1), .SETTLE_CYCLES(4)) i_dut (.*);
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [31:0] seen, exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask : check
  // Classic cycle held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Only the ack or the bench timeout may end this wait
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
    // Ack must stand for a single cycle only
    check(wb_ack_o, 1'b0, "ack pulse");
  endtask : wb
  function automatic logic [2:0] mult(input int c);
    return (c == 0) ? 3'h0 : 3'h1 << (c - 1);
  endfunction : mult
  task automatic t_reset();
    check(ref_ready_o, 1'b1, "ready");
    check(ref_enable_o, 1'b0, "ref");
    wb(1'b0, 8'h00, 32'h0, 4'h1);
    check(rd, 32'h40, "reset read");
    $display("reset test done");
  endtask : t_reset
  task automatic t_gains();
    logic [31:0] d;
    for (int c = 0; c < 4; c++) begin
      d = 32'h80 | ((3 - c) << 2) | c;
      wb(1'b1, 8'h00, d, 4'h1);
      check(ref_enable_o, 1'b1, "ref on");
      check(adc_buf_mult_o, mult(c), "adc");
      check(cmp_dac_buf_mult_o, mult(3 - c), "cmp");
      wb(1'b0, 8'h00, 32'h0, 4'h1);
      check(rd, d | 32'h40, "gain read");
    end
    wb(1'b1, 8'h00, 32'h0F, 4'h1);
    check(ref_enable_o, 1'b0, "ref off");
    check({adc_buf_on_o, cmp_dac_buf_on_o}, 2'h0, "buf off");
    $display("gain test done");
  endtask : t_gains
  task automatic t_temp();
    for (int r = 0; r < 2; r++) begin
      adc_chan_sel_i <= r ? 5'h1D : 5'h1C;
      wb(1'b1, 8'h00, 32'h20 | (r << 4), 4'h1);
      check(temp_bias_on_o, 1'b1, "bias");
      check(temp_high_range_o, r, "range");
      check(temp_adc_connect_o, r, "chan");
    end
    wb(1'b1, 8'h00, 32'h10, 4'h1);
    check(temp_bias_on_o, 1'b0, "bias off");
    check(temp_high_range_o, 1'b0, "range off");
    check(temp_adc_connect_o, 1'b0, "chan off");
    $display("temperature test done");
  endtask : t_temp
  // Unmapped and lane-masked writes must leave the register alone
  task automatic t_refused();
    wb(1'b1, 8'h04, 32'hFF, 4'h1);
    wb(1'b0, 8'h04, 32'h0, 4'h1);
    check(rd, 32'h0, "unmapped read");
    wb(1'b1, 8'h00, 32'hFF, 4'h0);
    wb(1'b0, 8'h00, 32'h0, 4'h1);
    check(rd, 32'h50, "masked write");
    $display("refusal test done");
  endtask : t_refused
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_gains();
    t_temp();
    t_refused();
    give_verdict();
  end
endmodule : fixed_ref_temp_sense_ctrl_tb
